// File: hdl/fbx_pkg.sv
/*
  fbx_pkg: shared types and constants for the frame/bound/shift/rotate
  execution datapath. Assumes a 16-bit core with byte-addressed memory.
*/
package fbx_pkg;

  localparam int unsigned WORD_W = 16;

  // operation codes handed over by the decoder
  typedef enum logic [3:0] {
    OP_FRAME_COLLAPSE     = 4'b0000,
    OP_BOUND_CHECK        = 4'b0001,
    OP_PUSH_IMM           = 4'b0010,
    OP_SIGNED_IMM_MUL     = 4'b0011,
    OP_ARITH_LEFT_SHIFT   = 4'b0100,
    OP_LOGIC_LEFT_SHIFT   = 4'b0101,
    OP_ARITH_RIGHT_SHIFT  = 4'b0110,
    OP_LOGIC_RIGHT_SHIFT  = 4'b0111,
    OP_ROTATE_LEFT        = 4'b1000,
    OP_ROTATE_RIGHT       = 4'b1001,
    OP_ROTATE_LEFT_CARRY  = 4'b1010,
    OP_ROTATE_RIGHT_CARRY = 4'b1011
  } fbx_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_POP  = 3'b010,
    ST_LO   = 3'b011,
    ST_HI   = 3'b100,
    ST_PUSH = 3'b101
  } fbx_state_t;

  localparam logic [7:0]  COUNT_MASK    = 8'h1F;
  localparam logic [7:0]  EXC_BOUND     = 8'h05;
  localparam logic [15:0] WORD_BYTES    = 16'h0002;

  // request from the decoder
  typedef struct packed {
    fbx_op_t     op;
    logic        wide;        // word operand / word immediate
    logic        rm_is_reg;   // limit operand encoded as a register
    logic [15:0] imm;         // immediate or count (low byte)
    logic [15:0] src;         // register or fetched memory operand
    logic [15:0] ea;          // effective address of memory operand
    logic [15:0] sp;
    logic [15:0] frame_base_register;
    logic        carry;       // carry flag in
  } fbx_cmd_t;

  // answer to the decoder
  typedef struct packed {
    logic [15:0] result;
    logic        wr_reg;
    logic        carry;
    logic        wr_carry;
    logic [15:0] new_sp;
    logic        wr_sp;
    logic [15:0] new_frame_base;
    logic        wr_frame_base;
    logic        exc;
    logic [7:0]  exc_type;
  } fbx_res_t;

endpackage

// File: hdl/fbx_shrot.sv
/*
  fbx_shrot: combinational shifter/rotator for byte or word operands.
  Assumes the count is already masked to 0..31 by the caller.
*/
`timescale 1ns/1ns
module fbx_shrot #(
  parameter bit LOGIC_RIGHT_ZERO_FILL = 1'b0
) (
  // operation
  input  fbx_pkg::fbx_op_t op,
  input  wire logic        wide,
  input  wire logic [4:0]  cnt,
  // operand
  input  wire logic [15:0] data,
  input  wire logic        cin,
  // result
  output logic      [15:0] res,
  output logic             cout
);
  import fbx_pkg::*;

  always_comb begin
    logic [15:0] v;
    logic        c;
    logic        top;
    logic        bot;
    int          msb;
    v   = data;
    c   = cin;
    top = 1'b0;
    bot = 1'b0;
    msb = wide ? 15 : 7;
    // one step per count; loop unrolls to a fixed 31-stage network
    for (int i = 0; i < 31; i++) begin
      if (i < int'(cnt)) begin
        top = v[msb];
        bot = v[0];
        case (op)
          OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: begin
            v = v << 1;
            c = top;
          end
          OP_ARITH_RIGHT_SHIFT: begin
            v      = v >> 1;
            v[msb] = top;
            c      = bot;
          end
          OP_LOGIC_RIGHT_SHIFT: begin
            v      = v >> 1;
            v[msb] = LOGIC_RIGHT_ZERO_FILL ? 1'b0 : top;
            c      = bot;
          end
          OP_ROTATE_LEFT: begin
            v    = v << 1;
            v[0] = top;
            c    = top;
          end
          OP_ROTATE_RIGHT: begin
            v      = v >> 1;
            v[msb] = bot;
            c      = bot;
          end
          OP_ROTATE_LEFT_CARRY: begin
            v    = v << 1;
            v[0] = c;
            c    = top;
          end
          OP_ROTATE_RIGHT_CARRY: begin
            v      = v >> 1;
            v[msb] = c;
            c      = bot;
          end
          default: begin
            v = v;
          end
        endcase
      end
    end
    res  = wide ? v : {8'h00, v[7:0]};
    cout = c;
  end

endmodule // fbx_shrot

// File: hdl/fbx_exec.sv
/*
  fbx_exec: execution datapath for frame collapse, signed bounds check,
  push immediate, immediate multiply and immediate shifts/rotates.
  Assumes the decoder and bus interface unit run on sys_clk; the memory
  port is a simple request/acknowledge master.
*/
// Notes on behaviour
// - frame collapse loads the stack pointer from the frame base, then pops the frame base.
// - bounds check compares the signed value to signed limits and raises type 5 outside them.
// - the lower limit is read at the effective address and the upper at the next word.
// - a register-encoded limit operand raises the invalid opcode exception instead.
// - push immediate takes a byte or word, sign-extending a byte before the stack write.
// - immediate multiply sign-extends a byte immediate and keeps the low 16 product bits.
// - the multiply source may be any register or memory, the result goes to a register.
// - immediate counts are masked with 1FH so no more than 31 positions are applied.
// - arithmetic and logical left shift are one operation that fills zeros on the right.
// - arithmetic right shift copies the original sign bit into vacated high bits.
// - logical right shift equals arithmetic right shift unless zero fill is chosen.
// - rotate left moves the top bit of a byte or word into the bottom bit.
// - rotate right moves the bottom bit of a byte or word into the top bit.
// - rotate left through carry moves carry into bit 0 and the top bit into carry.
// - rotate right through carry moves carry into the top bit and bit 0 into carry.
`timescale 1ns/1ns
module fbx_exec #(
  parameter logic [7:0] INVALID_OP_TYPE       = 8'h06,
  parameter bit         LOGIC_RIGHT_ZERO_FILL = 1'b0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // decoder request
  input  wire logic             cmd_valid,
  input  fbx_pkg::fbx_cmd_t     cmd,
  output logic                  cmd_ready_q,
  // decoder answer
  output logic                  done_q,
  output fbx_pkg::fbx_res_t     res_q,
  // memory port to bus interface
  output logic                  mem_rd_q,
  output logic                  mem_wr_q,
  output logic           [15:0] mem_addr_q,
  output logic           [15:0] mem_wdata_q,
  input  wire logic      [15:0] mem_rdata,
  input  wire logic             mem_ack
);
  import fbx_pkg::*;

  fbx_state_t  state_q;
  fbx_cmd_t    cmd_q;
  logic [15:0] lo_q;

  // decode and datapath terms
  wire         accept     = cmd_valid && cmd_ready_q;
  wire [15:0]  imm_sext   = cmd_q.wide ? cmd_q.imm
                                       : {{8{cmd_q.imm[7]}}, cmd_q.imm[7:0]};
  wire [31:0]  product    = $signed(cmd_q.src) * $signed(imm_sext);
  wire [15:0]  mul_low    = product[15:0];
  wire [7:0]   cnt_masked = cmd_q.imm[7:0] & COUNT_MASK;
  wire [15:0]  push_addr  = cmd_q.sp - WORD_BYTES;
  wire [15:0]  hi_addr    = cmd_q.ea + WORD_BYTES;
  wire         below_lo   = $signed(cmd_q.src) < $signed(lo_q);
  wire         above_hi   = $signed(cmd_q.src) > $signed(mem_rdata);
  wire         is_shift   = cmd_q.op[3] || cmd_q.op[2];
  wire [15:0]  sh_res;
  wire         sh_cout;

  fbx_shrot #(
    .LOGIC_RIGHT_ZERO_FILL (LOGIC_RIGHT_ZERO_FILL)
  ) u_shrot (
    .op   (cmd_q.op),
    .wide (cmd_q.wide),
    .cnt  (cnt_masked[4:0]),
    .data (cmd_q.src),
    .cin  (cmd_q.carry),
    .res  (sh_res),
    .cout (sh_cout)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      cmd_q       <= '0;
      lo_q        <= 16'h0000;
      cmd_ready_q <= 1'b1;
      done_q      <= 1'b0;
      res_q       <= '0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (accept) begin
            cmd_q       <= cmd;
            cmd_ready_q <= 1'b0;
            res_q       <= '0;
            state_q     <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cmd_q.op == OP_FRAME_COLLAPSE) begin
            res_q.new_sp <= cmd_q.frame_base_register;
            mem_rd_q     <= 1'b1;
            mem_addr_q   <= cmd_q.frame_base_register;
            state_q      <= ST_POP;
          end else if (cmd_q.op == OP_BOUND_CHECK) begin
            if (cmd_q.rm_is_reg) begin
              res_q.exc      <= 1'b1;
              res_q.exc_type <= INVALID_OP_TYPE;
              done_q         <= 1'b1;
              cmd_ready_q    <= 1'b1;
              state_q        <= ST_IDLE;
            end else begin
              mem_rd_q   <= 1'b1;
              mem_addr_q <= cmd_q.ea;
              state_q    <= ST_LO;
            end
          end else if (cmd_q.op == OP_PUSH_IMM) begin
            mem_wr_q    <= 1'b1;
            mem_addr_q  <= push_addr;
            mem_wdata_q <= imm_sext;
            state_q     <= ST_PUSH;
          end else begin
            // multiply and shifts finish here; destination is always a register
            res_q.result   <= is_shift ? sh_res : mul_low;
            res_q.wr_reg   <= 1'b1;
            // zero count leaves carry untouched
            res_q.carry    <= sh_cout;
            res_q.wr_carry <= is_shift && (cnt_masked != 8'h00);
            done_q         <= 1'b1;
            cmd_ready_q    <= 1'b1;
            state_q        <= ST_IDLE;
          end
        end
        ST_POP: begin
          if (mem_ack) begin
            mem_rd_q     <= 1'b0;
            res_q.new_frame_base <= mem_rdata;
            res_q.wr_frame_base  <= 1'b1;
            res_q.new_sp <= res_q.new_sp + WORD_BYTES;
            res_q.wr_sp  <= 1'b1;
            done_q       <= 1'b1;
            cmd_ready_q  <= 1'b1;
            state_q      <= ST_IDLE;
          end
        end
        ST_LO: begin
          if (mem_ack) begin
            lo_q       <= mem_rdata;
            mem_addr_q <= hi_addr;
            state_q    <= ST_HI;
          end
        end
        ST_HI: begin
          if (mem_ack) begin
            mem_rd_q       <= 1'b0;
            res_q.exc      <= below_lo || above_hi;
            res_q.exc_type <= EXC_BOUND;
            done_q         <= 1'b1;
            cmd_ready_q    <= 1'b1;
            state_q        <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          if (mem_ack) begin
            mem_wr_q     <= 1'b0;
            res_q.new_sp <= push_addr;
            res_q.wr_sp  <= 1'b1;
            done_q       <= 1'b1;
            cmd_ready_q  <= 1'b1;
            state_q      <= ST_IDLE;
          end
        end
        default: begin
          // illegal code: recover to idle
          mem_rd_q    <= 1'b0;
          mem_wr_q    <= 1'b0;
          cmd_ready_q <= 1'b1;
          state_q     <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // fbx_exec

// File: bench/fbx_bus_model.sv
/*
  fbx_bus_model: bus interface unit model, word memory with ack.
  Assumes requests held until ack; lag sets the added wait cycles.
*/
`timescale 1ns/1ns
module fbx_bus_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  lag,
  // answer
  output logic      [15:0] rdata,
  output logic             ack
);
  logic [15:0] mem [0:255];
  int          n;
  // no ack in the cycle after an ack, so a changed address is a new request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      n <= 0;
      rdata <= 16'h0000;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if ((rd || wr) && !ack && n >= lag) begin
        ack <= 1'b1;
        n <= 0;
        if (wr) mem[addr[8:1]] <= wdata;
        else rdata <= mem[addr[8:1]];
      end else if (rd || wr) begin
        n <= n + 1;
      end
    end
  end
endmodule // fbx_bus_model

// File: bench/fbx_exec_checker.sv
/*
  fbx_exec_checker: port assertions for fbx_exec.
  Assumes the single sys_clk domain; bound into every fbx_exec.
*/
`timescale 1ns/1ns
module fbx_exec_checker import fbx_pkg::*; #(
  parameter logic [7:0] INVALID_OP_TYPE = 8'h06
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // decoder side
  input  wire logic         cmd_valid,
  input  fbx_pkg::fbx_cmd_t cmd,
  input  wire logic         cmd_ready_q,
  input  wire logic         done_q,
  input  fbx_pkg::fbx_res_t res_q,
  // memory side
  input  wire logic         mem_rd_q,
  input  wire logic         mem_wr_q,
  input  wire logic [15:0]  mem_addr_q,
  input  wire logic [15:0]  mem_wdata_q,
  input  wire logic [15:0]  mem_rdata,
  input  wire logic         mem_ack
);
  wire logic        acc  = cmd_valid && cmd_ready_q;
  wire logic [15:0] simm = cmd.wide ? cmd.imm : {{8{cmd.imm[7]}}, cmd.imm[7:0]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_busy; acc |=> !cmd_ready_q; endproperty
  a_busy: assert property (p_busy) else $error("ready high after accept");
  property p_pulse; done_q |=> !done_q; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_mul; acc && cmd.op == OP_SIGNED_IMM_MUL |-> ##2 done_q && res_q.wr_reg
    && res_q.result == 16'($past(cmd.src, 2) * $past(simm, 2)); endproperty
  a_mul: assert property (p_mul) else $error("multiply result wrong");
  property p_left; acc && cmd.op inside {OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT}
    && cmd.wide |-> ##2 done_q
    && res_q.result == ($past(cmd.src, 2) << $past(cmd.imm[4:0], 2)); endproperty
  a_left: assert property (p_left) else $error("left shift wrong");
  property p_breg; acc && cmd.op == OP_BOUND_CHECK && cmd.rm_is_reg |-> ##2 done_q
    && res_q.exc && res_q.exc_type == INVALID_OP_TYPE && !mem_rd_q; endproperty
  a_breg: assert property (p_breg) else $error("register limit not refused");
  property p_blo; acc && cmd.op == OP_BOUND_CHECK && !cmd.rm_is_reg
    |-> ##2 mem_rd_q && mem_addr_q == $past(cmd.ea, 2); endproperty
  a_blo: assert property (p_blo) else $error("lower limit address wrong");
  property p_push; acc && cmd.op == OP_PUSH_IMM |-> ##2 mem_wr_q && mem_wdata_q == $past(simm, 2)
    && mem_addr_q == $past(cmd.sp, 2) - 16'h0002; endproperty
  a_push: assert property (p_push) else $error("push write wrong");
  property p_pop; acc && cmd.op == OP_FRAME_COLLAPSE
    |-> ##2 mem_rd_q && mem_addr_q == $past(cmd.frame_base_register, 2); endproperty
  a_pop: assert property (p_pop) else $error("frame pop address wrong");
  property p_hold; (mem_rd_q || mem_wr_q) && !mem_ack
    |=> (mem_rd_q || mem_wr_q) && $stable(mem_addr_q); endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped early");
endmodule // fbx_exec_checker
bind fbx_exec fbx_exec_checker #(.INVALID_OP_TYPE(INVALID_OP_TYPE)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q),
  .done_q(done_q), .res_q(res_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
  .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

// File: bench/fbx_exec_bench.sv
/*
  fbx_exec_bench: drives fbx_exec against a reference model.
  Assumes fbx_bus_model as bus unit and the bound checker.
*/
`timescale 1ns/1ns
module fbx_exec_bench;
  import fbx_pkg::*;
  logic        sys_clk = 0, rst = 1, cmd_valid = 0, w, c, mem_ack, cmd_ready_q, done_q;
  logic        mem_rd_q, mem_wr_q;
  logic [1:0]  lag = 2'h0;
  logic [15:0] s, imm, mem_rdata, mem_addr_q, mem_wdata_q;
  logic [16:0] e;
  logic [15:0] bt [5] = '{16'hfffa, 16'hfffb, 16'h0007, 16'h0008, 16'h8000};
  logic [31:0] seed = 32'h0000_ab04;
  fbx_cmd_t    cmd = '0;
  fbx_res_t    res_q;
  fbx_op_t     op;
  int          num_errors = 0, checks_done = 0, p;
  always #5 sys_clk = ~sys_clk;
  fbx_exec dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready_q(cmd_ready_q), .done_q(done_q), .res_q(res_q), .mem_rd_q(mem_rd_q),
    .mem_wr_q(mem_wr_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  fbx_bus_model bus (.clk(sys_clk), .rst(rst), .rd(mem_rd_q), .wr(mem_wr_q), .addr(mem_addr_q),
    .wdata(mem_wdata_q), .lag(lag), .rdata(mem_rdata), .ack(mem_ack));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // step by step, so masking and carry order stay independent of the shifter
  function automatic logic [16:0] model(fbx_op_t o, logic w, logic [15:0] d, int n, logic c);
    int   m;
    logic t;
    m = w ? 15 : 7;
    if (!w) d[15:8] = 8'h00;
    repeat (n) begin
      t = (o inside {OP_ARITH_RIGHT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_ROTATE_RIGHT,
                     OP_ROTATE_RIGHT_CARRY}) ? d[0] : d[m];
      case (o)
        OP_ARITH_LEFT_SHIFT, OP_LOGIC_LEFT_SHIFT: d = d << 1;
        OP_ROTATE_LEFT: d = d << 1 | t;
        OP_ROTATE_LEFT_CARRY: d = d << 1 | c;
        OP_ROTATE_RIGHT: begin
          d    = d >> 1;
          d[m] = t;
        end
        OP_ROTATE_RIGHT_CARRY: begin
          d    = d >> 1;
          d[m] = c;
        end
        default: begin
          d    = d >> 1;
          d[m] = d[m-1];
        end
      endcase
      c = t;
      if (!w) d[15:8] = 8'h00;
    end
    return {c, d};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // called just after an edge; returns just after the done edge
  task automatic run(fbx_op_t o, logic [15:0] i, logic [15:0] d, logic [15:0] a, logic r);
    cmd = '{o, w, r, i, d, a, a, a, c};
    lag = 2'(rnd());
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    for (int k = 0; k < 40 && done_q !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(done_q, 1'b1);
  endtask
  initial begin
    #100000;
    chk(16'h0000, 16'h0001);
    complete_run;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    w = 1'b1;
    c = 1'b0;
    bus.mem[8'h20] = 16'(rnd());
    run(OP_FRAME_COLLAPSE, 16'h0000, 16'h0000, 16'h0040, 1'b0);
    chk(res_q.new_frame_base, bus.mem[8'h20]);
    chk({res_q.new_sp, res_q.wr_sp, res_q.wr_frame_base}, {16'h0042, 2'b11});
    bus.mem[8'h30] = 16'hfffb;
    bus.mem[8'h31] = 16'h0007;
    foreach (bt[k]) begin
      run(OP_BOUND_CHECK, 16'h0000, bt[k], 16'h0060, 1'b0);
      p = ($signed(bt[k]) < -5 || $signed(bt[k]) > 7);
      chk({res_q.exc, res_q.exc_type}, {p[0], 8'h05});
    end
    run(OP_BOUND_CHECK, 16'h0000, 16'h8000, 16'h0060, 1'b1);
    chk({res_q.exc, res_q.exc_type}, {1'b1, 8'h06});
    for (int k = 0; k < 2; k++) begin
      w = k[0];
      imm = k ? 16'(rnd()) : 16'h0080;
      run(OP_PUSH_IMM, imm, 16'h0000, 16'h0080, 1'b0);
      chk(bus.mem[8'h3f], k ? imm : 16'hff80);
      chk(res_q.new_sp, 16'h007e);
    end
    repeat (8) begin
      s = 16'(rnd());
      imm = 16'(rnd());
      w = 1'(rnd());
      p = $signed(s) * (w ? $signed(imm) : $signed(imm[7:0]));
      run(OP_SIGNED_IMM_MUL, imm, s, 16'h0000, 1'b0);
      chk({res_q.result, res_q.wr_reg}, {p[15:0], 1'b1});
    end
    for (int k = 4; k < 12; k++) begin
      op = fbx_op_t'(k);
      for (int j = 0; j < 7; j++) begin
        s = 16'(rnd());
        imm = (j < 2) ? 16'(j * 31) : 16'(rnd());
        w = 1'(rnd());
        c = 1'(rnd());
        e = model(op, w, s, imm[4:0], c);
        run(op, imm, s, 16'h0000, 1'b0);
        chk(res_q.result, e[15:0]);
        chk(res_q.wr_carry, imm[4:0] != 0);
        if (imm[4:0] != 0) chk(res_q.carry, e[16]);
      end
    end
    complete_run;
  end
endmodule // fbx_exec_bench
